// file: ffc_pkg.sv
// Package with register map, field layout and reset values for the frame filter control block
// =====================================================================
// What this block does
// - Set-only bits accept written ones only
// - Clear-only bits accept written zeros only
// - Effective-value reads return value actually used
// - Reject when reserved mask ANDs frame bits
// - Reject frame version above configured maximum
// - Coordinator accepts frames without destination address
// - Enable bit applies third-level frame filtering
// - Decision uses config, type filter, address info
// - Filtering off ignores config and accepts all
// - Config byte resets to 0x0d
// - Accept bits per type for types 0-3, one shared bit for types 4-7, zero rejects
// - Frame type top bit altered before filtering
package ffc_pkg;
   // =====================================================================
   // Register byte addresses
   localparam logic [11:0] FILT_CFG_ADDR  = 12'h000;
   localparam logic [11:0] TYPE_CFG_ADDR  = 12'h004;
   localparam logic [11:0] SRC_CFG_ADDR   = 12'h008;
   localparam logic [11:0] CTRL_ADDR      = 12'h00c;
   localparam logic [11:0] STATUS_ADDR    = 12'h010;
   localparam logic [11:0] CAL_ADDR       = 12'h014;
   // =====================================================================
   // Reset values
   localparam logic [7:0]  FILT_CFG_RST   = 8'h0d;
   localparam logic [7:0]  TYPE_CFG_RST   = 8'h78;
   localparam logic [7:0]  SRC_CFG_RST    = 8'h07;
   localparam logic [7:0]  CAL_RST        = 8'h00;
   // =====================================================================
   // Field positions of the filter configuration byte
   localparam int FILT_EN_BIT   = 0;
   localparam int COORD_BIT     = 1;
   localparam int VER_LO        = 2;
   localparam int VER_HI        = 3;
   localparam int RMASK_LO      = 4;
   localparam int RMASK_HI      = 6;
   // Field positions of the type filter byte
   localparam int ALTER_LO      = 1;
   localparam int ALTER_HI      = 2;
   localparam int ACCEPT_LO     = 3;
   // Frame control field positions
   localparam int FCF_TYPE_LO   = 0;
   localparam int FCF_TYPE_HI   = 2;
   localparam int FCF_RSV_LO    = 7;
   localparam int FCF_RSV_HI    = 9;
   localparam int FCF_DAM_LO    = 10;
   localparam int FCF_DAM_HI    = 11;
   localparam int FCF_VER_LO    = 12;
   localparam int FCF_VER_HI    = 13;
   // Control register bit positions
   localparam int CTRL_OVR_BIT  = 0;
   localparam int CTRL_CLR_BIT  = 1;
   // Writable masks: reserved bits are stored as zero
   localparam logic [7:0]  FILT_CFG_WMASK = 8'h7f;
   localparam logic [7:0]  TYPE_CFG_WMASK = 8'hfe;
   localparam logic [7:0]  SRC_CFG_WMASK  = 8'h07;
   // Type top-bit alteration modes
   typedef enum logic [1:0] {
      ALT_KEEP   = 2'b00,
      ALT_INVERT = 2'b01,
      ALT_ZERO   = 2'b10,
      ALT_ONE    = 2'b11
   } ffc_alter_t;
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
endpackage

// file: ffc_top.sv
// Frame filter control block with AHB-Lite register slave and filter decision
`timescale 1ns/1ps
module ffc_top (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Received frame header
   input  wire logic        frame_valid,
   input  wire logic [15:0] frame_ctrl,
   input  wire logic        dest_addr_match,
   // Automatic calibration source for the effective-value field
   input  wire logic [7:0]  cal_auto_value,
   // Filter decision
   output logic             frame_accept,
   output logic             frame_reject,
   output logic [7:0]       cal_effective
);
   // =====================================================================
   // Registers
   logic [7:0]  frame_filter_config_r;
   logic [7:0]  frame_filter_config_nxt;
   logic [7:0]  frame_type_filter_config_r;
   logic [7:0]  frame_type_filter_config_nxt;
   logic [7:0]  source_match_config_r;
   logic [7:0]  source_match_config_nxt;
   logic [7:0]  cal_override_r;
   logic [7:0]  cal_override_nxt;
   logic        override_en_r;
   logic        override_en_nxt;
   logic [7:0]  cal_effective_nxt;
   logic [7:0]  reject_count_r;
   logic [7:0]  reject_count_nxt;
   logic [7:0]  accept_count_r;
   logic [7:0]  accept_count_nxt;
   logic        wr_pend_r;
   logic [11:0] wr_addr_r;
   // =====================================================================
   // Address phase capture
   logic        ap_valid;
   assign ap_valid  = hsel & hready & (htrans == ffc_pkg::HTRANS_NONSEQ);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
      end else begin
         wr_pend_r <= ap_valid & hwrite;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_addr_r <= 12'h000;
      end else if (ap_valid) begin
         wr_addr_r <= haddr;
      end
   end
   // =====================================================================
   // Write decode for the pending data phase
   logic wr_filt;
   logic wr_type;
   logic wr_src;
   logic wr_ctrl;
   logic wr_cal;

   always_comb begin
      wr_filt = 1'b0;
      wr_type = 1'b0;
      wr_src  = 1'b0;
      wr_ctrl = 1'b0;
      wr_cal  = 1'b0;

      if (!wr_pend_r) begin
         wr_filt = 1'b0;
      end else if (wr_addr_r == ffc_pkg::FILT_CFG_ADDR) begin
         wr_filt = 1'b1;
      end else if (wr_addr_r == ffc_pkg::TYPE_CFG_ADDR) begin
         wr_type = 1'b1;
      end else if (wr_addr_r == ffc_pkg::SRC_CFG_ADDR) begin
         wr_src = 1'b1;
      end else if (wr_addr_r == ffc_pkg::CTRL_ADDR) begin
         wr_ctrl = 1'b1;
      end else if (wr_addr_r == ffc_pkg::CAL_ADDR) begin
         wr_cal = 1'b1;
      end
   end
   // =====================================================================
   // Configuration next values, reserved bits stored as zero
   always_comb begin
      frame_filter_config_nxt = frame_filter_config_r;
      if (wr_filt) begin
         frame_filter_config_nxt = hwdata[7:0] & ffc_pkg::FILT_CFG_WMASK;
      end
   end

   always_comb begin
      frame_type_filter_config_nxt = frame_type_filter_config_r;
      if (wr_type) begin
         frame_type_filter_config_nxt = hwdata[7:0] & ffc_pkg::TYPE_CFG_WMASK;
      end
   end

   always_comb begin
      source_match_config_nxt = source_match_config_r;
      if (wr_src) begin
         source_match_config_nxt = hwdata[7:0] & ffc_pkg::SRC_CFG_WMASK;
      end
   end

   always_comb begin
      cal_override_nxt = cal_override_r;
      if (wr_cal) begin
         cal_override_nxt = hwdata[7:0];
      end
   end
   // =====================================================================
   // Configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_filter_config_r <= ffc_pkg::FILT_CFG_RST;
      end else begin
         frame_filter_config_r <= frame_filter_config_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_type_filter_config_r <= ffc_pkg::TYPE_CFG_RST;
      end else begin
         frame_type_filter_config_r <= frame_type_filter_config_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         source_match_config_r <= ffc_pkg::SRC_CFG_RST;
      end else begin
         source_match_config_r <= source_match_config_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cal_override_r <= ffc_pkg::CAL_RST;
      end else begin
         cal_override_r <= cal_override_nxt;
      end
   end
   // =====================================================================
   // Control bits: set-only override enable, clear-only counter clear bit
   logic clear_req;
   assign clear_req = wr_ctrl & ~hwdata[ffc_pkg::CTRL_CLR_BIT];

   always_comb begin
      override_en_nxt = override_en_r;
      if (wr_ctrl && hwdata[ffc_pkg::CTRL_OVR_BIT]) begin
         override_en_nxt = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         override_en_r <= 1'b0;
      end else begin
         override_en_r <= override_en_nxt;
      end
   end
   // =====================================================================
   // Effective value seen by the module
   assign cal_effective_nxt = override_en_r ? cal_override_r : cal_auto_value;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cal_effective <= ffc_pkg::CAL_RST;
      end else begin
         cal_effective <= cal_effective_nxt;
      end
   end
   // =====================================================================
   // Filter decision
   logic [2:0] ftype_alt;
   logic       type_ok;
   logic       rsv_ok;
   logic       ver_ok;
   logic       dest_ok;
   logic       pass;

   always_comb begin
      ftype_alt = frame_ctrl[ffc_pkg::FCF_TYPE_HI:ffc_pkg::FCF_TYPE_LO];
      case (ffc_pkg::ffc_alter_t'(frame_type_filter_config_r[ffc_pkg::ALTER_HI:ffc_pkg::ALTER_LO]))
         ffc_pkg::ALT_KEEP:   ftype_alt[2] = frame_ctrl[ffc_pkg::FCF_TYPE_HI];
         ffc_pkg::ALT_INVERT: ftype_alt[2] = ~frame_ctrl[ffc_pkg::FCF_TYPE_HI];
         ffc_pkg::ALT_ZERO:   ftype_alt[2] = 1'b0;
         default:             ftype_alt[2] = 1'b1;
      endcase
      if (ftype_alt[2]) begin
         type_ok = frame_type_filter_config_r[7];
      end else begin
         type_ok = frame_type_filter_config_r[ffc_pkg::ACCEPT_LO + {1'b0, ftype_alt[1:0]}];
      end
      rsv_ok = ~|(frame_filter_config_r[ffc_pkg::RMASK_HI:ffc_pkg::RMASK_LO]
                  & frame_ctrl[ffc_pkg::FCF_RSV_HI:ffc_pkg::FCF_RSV_LO]);
      ver_ok = frame_ctrl[ffc_pkg::FCF_VER_HI:ffc_pkg::FCF_VER_LO]
               <= frame_filter_config_r[ffc_pkg::VER_HI:ffc_pkg::VER_LO];
      if (frame_ctrl[ffc_pkg::FCF_DAM_HI:ffc_pkg::FCF_DAM_LO] == 2'b00) begin
         dest_ok = frame_filter_config_r[ffc_pkg::COORD_BIT];
      end else begin
         dest_ok = dest_addr_match;
      end
      if (frame_filter_config_r[ffc_pkg::FILT_EN_BIT]) begin
         pass = type_ok & rsv_ok & ver_ok & dest_ok;
      end else begin
         pass = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_accept <= 1'b0;
         frame_reject <= 1'b0;
      end else begin
         frame_accept <= frame_valid & pass;
         frame_reject <= frame_valid & ~pass;
      end
   end
   // =====================================================================
   // Decision counters, cleared by writing zero to the clear-only bit
   always_comb begin
      accept_count_nxt = accept_count_r + {7'h00, frame_accept};
      if (clear_req) begin
         accept_count_nxt = 8'h00;
      end
   end

   always_comb begin
      reject_count_nxt = reject_count_r + {7'h00, frame_reject};
      if (clear_req) begin
         reject_count_nxt = 8'h00;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         accept_count_r <= 8'h00;
      end else begin
         accept_count_r <= accept_count_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reject_count_r <= 8'h00;
      end else begin
         reject_count_r <= reject_count_nxt;
      end
   end
   // =====================================================================
   // Read data, taken at the address phase from the values of the data phase
   logic        rd_req;
   logic [31:0] rd_word;
   assign rd_req = ap_valid & ~hwrite;

   always_comb begin
      rd_word = 32'h0000_0000;
      if (!rd_req) begin
         rd_word = 32'h0000_0000;
      end else if (haddr == ffc_pkg::FILT_CFG_ADDR) begin
         rd_word[7:0] = frame_filter_config_nxt;
      end else if (haddr == ffc_pkg::TYPE_CFG_ADDR) begin
         rd_word[7:0] = frame_type_filter_config_nxt;
      end else if (haddr == ffc_pkg::SRC_CFG_ADDR) begin
         rd_word[7:0] = source_match_config_nxt;
      end else if (haddr == ffc_pkg::CTRL_ADDR) begin
         rd_word[1:0] = {1'b1, override_en_nxt};
      end else if (haddr == ffc_pkg::STATUS_ADDR) begin
         rd_word[15:0] = {reject_count_nxt, accept_count_nxt};
      end else if (haddr == ffc_pkg::CAL_ADDR) begin
         rd_word[7:0] = cal_effective_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else begin
         hrdata <= rd_word;
      end
   end
endmodule

// file: ffc_sva.sv
// Checker for the filter decision and configuration readback
`timescale 1ns/1ps
module ffc_sva (
   // Bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [11:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   // Frame
   input wire logic        frame_valid,
   input wire logic [15:0] frame_ctrl,
   input wire logic        frame_accept,
   input wire logic        frame_reject
);
   // ==========
   // Shadow of the filter configuration
   logic       wr_r;
   logic       rd_r;
   logic [6:0] cfg_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_r <= 1'b0;
         rd_r <= 1'b0;
      end else begin
         wr_r <= hsel && hready && htrans == 2'b10 && hwrite && haddr == 12'h000;
         rd_r <= hsel && hready && htrans == 2'b10 && !hwrite && haddr == 12'h000;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cfg_r <= 7'h0d;
      else if (wr_r) cfg_r <= hwdata[6:0];
   end
   // ==========
   // Assertions
   logic no_dest;
   logic ver_over;
   assign no_dest  = frame_ctrl[11:10] == 2'b00;
   assign ver_over = frame_ctrl[13:12] > cfg_r[3:2];
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_one_verdict: assert property (!(frame_accept && frame_reject))
      else $error("two verdicts");
   a_verdict_cause: assert property ((frame_accept || frame_reject) |-> $past(frame_valid))
      else $error("verdict without frame");
   a_verdict_given: assert property (frame_valid |=> frame_accept != frame_reject)
      else $error("no verdict");
   a_mask_reject: assert property (frame_valid && cfg_r[0] && |(cfg_r[6:4] & frame_ctrl[9:7]) |=> frame_reject)
      else $error("mask hit accepted");
   a_version_reject: assert property (frame_valid && cfg_r[0] && ver_over |=> frame_reject)
      else $error("version accepted");
   a_no_dest_reject: assert property (frame_valid && cfg_r[0] && !cfg_r[1] && no_dest |=> frame_reject)
      else $error("no destination accepted");
   a_off_accept: assert property (frame_valid && !cfg_r[0] |=> frame_accept)
      else $error("unfiltered frame rejected");
   a_cfg_readback: assert property (rd_r |-> hrdata[7:0] == {1'b0, cfg_r})
      else $error("config readback wrong");
   cover property (frame_valid && cfg_r[0] ##1 frame_accept);
   cover property (frame_valid ##1 frame_reject);
   cover property (wr_r);
endmodule
bind ffc_top ffc_sva u_ffc_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready),
   .haddr(haddr), .htrans(htrans), .hwdata(hwdata), .hrdata(hrdata), .frame_valid(frame_valid),
   .frame_ctrl(frame_ctrl), .frame_accept(frame_accept), .frame_reject(frame_reject));

// file: ffc_host_model.sv
// Host bus master model for the register slave
`timescale 1ns/1ps
module ffc_host_model (
   // Answer
   input  wire logic        hclk,
   input  wire logic        hreadyout,
   input  wire logic [31:0] hrdata,
   // Request
   output logic             hsel = 1'b0,
   output logic [11:0]      haddr = 12'h000,
   output logic [1:0]       htrans = 2'b00,
   output logic             hwrite = 1'b0,
   output logic [2:0]       hsize = 3'b010,
   output logic [31:0]      hwdata = 32'h0
);
   task automatic wait_rdy(output bit ok);
      ok = 1'b0;
      for (int n = 0; n < 16 && !ok; n++) begin
         @(posedge hclk);
         ok = hreadyout === 1'b1;
      end
   endtask
   task automatic xfer(input bit w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] rd, output bit ok);
      bit ok2;
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy(ok);
      htrans <= 2'b00;
      hwdata <= {24'h0, (a == 12'h000) ? d & 8'h7f : d};
      wait_rdy(ok2);
      rd = hrdata;
      ok = ok && ok2;
      hsel   <= 1'b0;
      hwdata <= ~hwdata;
   endtask
endmodule

// file: tb_frame_filter_control.sv
// Self-checking testbench for the frame filter control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_frame_filter_control;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel, hwrite, rdy, hresp, fv = 1'b0, dm = 1'b0, acc, rej;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata;
   logic [15:0] fctl = 16'h0;
   logic [7:0]  cal = 8'h00, cal_eff, na = 8'h00, nr = 8'h00;
   logic [11:0] ra [4] = '{12'h000, 12'h004, 12'h008, 12'h020};
   logic [31:0] rv [4] = '{32'h0d, 32'h78, 32'h07, 32'h0};
   int          error_cnt = 0, checked = 0;
   integer      seed = 32'h3bb5945d;
   always #12.5 hclk = ~hclk;
   ffc_host_model host (.hclk(hclk), .hreadyout(rdy), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   ffc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(hresp),
      .frame_valid(fv), .frame_ctrl(fctl), .dest_addr_match(dm), .cal_auto_value(cal),
      .frame_accept(acc), .frame_reject(rej), .cal_effective(cal_eff));
   task automatic finish_test;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic bus(input bit w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r);
      bit ok;
      host.xfer(w, a, d, r, ok);
      if (!ok) begin
         error_cnt++;
         finish_test();
      end
   endtask
   function automatic logic model(logic [7:0] c, tc, logic [15:0] fc, logic m);
      logic [2:0] t;
      t = fc[2:0];
      if (tc[2:1] == 2'b01) t[2] = ~t[2];
      if (tc[2]) t[2] = tc[1];
      if (!c[0]) return 1'b1;
      if (|(c[6:4] & fc[9:7]) || fc[13:12] > c[3:2]) return 1'b0;
      if (!(t[2] ? tc[7] : tc[3 + t[1:0]])) return 1'b0;
      return (fc[11:10] == 2'b00) ? c[1] : m;
   endfunction
   task automatic frame(input logic [15:0] fc, input logic m, input logic e);
      @(posedge hclk);
      fv   <= 1'b1;
      fctl <= fc;
      dm   <= m;
      @(posedge hclk);
      fv   <= 1'b0;
      @(negedge hclk);
      `CHK("accept", e, acc)
      `CHK("reject", ~e, rej)
      if (e) na++;
      else nr++;
   endtask
   initial begin
      logic [31:0] r;
      logic [7:0]  c, tc;
      logic [15:0] fc;
      logic        m;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (ra[i]) begin
         bus(0, ra[i], 0, r);
         `CHK("reset value", rv[i], r)
      end
      `CHK("okay response", 1'b0, hresp)
      $display("test reset values done");
      cal <= 8'ha3;
      bus(1, 12'h014, 8'h5c, r);
      bus(0, 12'h014, 0, r);
      `CHK("cal auto", 32'ha3, r)
      bus(1, 12'h00c, 8'h02, r);
      bus(0, 12'h00c, 0, r);
      `CHK("ctrl zero kept", 32'h02, r)
      bus(1, 12'h00c, 8'h03, r);
      bus(0, 12'h014, 0, r);
      `CHK("cal override", 32'h5c, r)
      `CHK("cal port", 8'h5c, cal_eff)
      bus(1, 12'h00c, 8'h02, r);
      bus(0, 12'h00c, 0, r);
      `CHK("ctrl one kept", 32'h03, r)
      $display("test access kinds done");
      for (int i = 0; i < 48; i++) begin
         if (i % 8 == 0) begin
            c = 8'($random(seed));
            c[0] = i < 40;
            tc = 8'($random(seed));
            tc[2:1] = 2'(i / 8);
            tc[0] = 1'b0;
            bus(1, 12'h000, c, r);
            bus(1, 12'h004, tc, r);
         end
         fc = 16'($random(seed));
         fc[2:0] = 3'(i);
         m = 1'($random(seed));
         frame(fc, m, model(c, tc, fc, m));
      end
      $display("test random frames done");
      bus(0, 12'h010, 0, r);
      `CHK("status", {16'h0, nr, na}, r)
      bus(1, 12'h00c, 8'h02, r);
      bus(0, 12'h010, 0, r);
      `CHK("status kept", {16'h0, nr, na}, r)
      bus(1, 12'h00c, 8'h00, r);
      bus(0, 12'h010, 0, r);
      `CHK("status cleared", 32'h0, r)
      $display("test counter clear done");
      finish_test();
   end
endmodule
